// ### bench/ifm_interp_props.sv
`timescale 1ns/1ps
module ifm_interp_props (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // samples and oscillator
    input wire logic out_valid,
    input wire ifm_pkg::ifm_sample_type out_i,
    input wire logic [2:0] out_phase,
    input wire logic [31:0] carrier_phase,
    input wire logic [31:0] active_tuning_word
);
    import ifm_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire upd = acc && pwrite && paddr == 12'h0D8 && pwdata[0];
    wire hit = paddr inside {12'h070, 12'h074, 12'h078, 12'h07C, 12'h0C0,
        12'h0D8, 12'h100};
    sequence s_rd6;
        psel && !pwrite && (paddr == 12'h074 || paddr == 12'h078);
    endsequence
    sequence s_start;
        $rose(out_valid);
    endsequence
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_err; acc && !hit |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no slverr");
    property p_m1;
        psel && !pwrite && paddr == 12'h070 |-> prdata[31:2] == 30'h0;
    endproperty
    a_m1: assert property (p_m1) else $error("mode1 wide");
    property p_m6; s_rd6 |-> prdata[31:6] == 26'h0; endproperty
    a_m6: assert property (p_m6) else $error("mode2/3 wide");
    // the word may land one cycle after the access edge
    property p_ftw; $changed(active_tuning_word) |-> $past(upd) || $past(upd, 2);
    endproperty
    a_ftw: assert property (p_ftw) else $error("word moved");
    property p_nco;
        carrier_phase == $past(carrier_phase) || carrier_phase ==
            $past(carrier_phase) + $past(active_tuning_word);
    endproperty
    a_nco: assert property (p_nco) else $error("phase step");
    property p_start; s_start |-> out_phase == 3'h0; endproperty
    a_start: assert property (p_start) else $error("burst start");
    property p_step;
        out_valid && out_phase != 3'h0 |-> $past(out_valid) &&
            out_phase == $past(out_phase) + 3'h1 && out_i == $past(out_i);
    endproperty
    a_step: assert property (p_step) else $error("burst step");
endmodule
bind ifm_interp ifm_interp_props chk_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .out_valid, .out_i,
    .out_phase, .carrier_phase, .active_tuning_word);

// ### bench/ifm_src_model.sv
`timescale 1ns/1ps
module ifm_src_model (
    // clock
    input wire logic pclk,
    // sample handshake
    input wire logic in_ready,
    output logic in_valid = 1'h0,
    output ifm_pkg::ifm_sample_type in_i = 16'h0,
    output ifm_pkg::ifm_sample_type in_q = 16'h0
);
    import ifm_pkg::*;
    // released lines show the inverse so a stale sample never looks fresh
    task automatic send(input ifm_sample_type i, input ifm_sample_type q);
        int n;
        repeat (1 + $urandom_range(2)) @(posedge pclk);
        in_valid <= 1'h1;
        in_i <= i;
        in_q <= q;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (in_ready !== 1'h1 && n < 300);
        if (n >= 300) tb.timeout();
        in_valid <= 1'h0;
        in_i <= ~i;
        in_q <= ~q;
    endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import ifm_pkg::*;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    n_errors++; $display("Error %s exp %h got %h", n, e, s); end end
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, carrier_phase, active_tuning_word, rd, w;
    logic pready, pslverr, in_valid, in_ready, out_valid, err;
    ifm_sample_type in_i, in_q, out_i, out_q;
    logic [2:0] out_phase;
    logic [34:0] eq[$];
    int n_errors, checks_done, n_out, acc;
    bit pm, full;
    // mode sets for 2x, 4x at half rate, 8x at input rate
    logic [31:0] m1s[3] = '{32'h0, 32'h1, 32'h2};
    logic [31:0] m2s[3] = '{32'h0, 32'h09, 32'h12};
    logic [31:0] m3s[3] = '{32'h0, 32'h0, 32'h09};
    logic [31:0] ctl[3] = '{32'h0, 32'h3, 32'h6};
    ifm_interp dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_i,
        .in_q, .out_valid, .out_i, .out_q, .out_phase, .carrier_phase,
        .active_tuning_word);
    ifm_src_model src_u (.pclk, .in_ready, .in_valid, .in_i, .in_q);
    always #5 pclk = ~pclk;
    function automatic ifm_sample_type sg(ifm_sample_type v);
        return pm && acc[0] ? -v : v;
    endfunction
    // ----------------------------------------
    // reference model: n_out held copies per taken sample
    // ----------------------------------------
    always @(posedge pclk) begin
        logic [34:0] ev;
        if (in_valid === 1'h1 && in_ready === 1'h1) begin
            for (int k = 0; k < n_out; k++) begin
                eq.push_back({k[2:0], sg(in_i), sg(in_q)});
            end
            acc++;
        end
        if (in_ready === 1'h0) full = 1'h1;
        if (out_valid === 1'h1) begin
            ev = eq.size() != 0 ? eq.pop_front() : 'x;
            `CHK("sample", ev, {out_phase, out_i, out_q})
        end
    end
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic timeout();
        n_errors++;
        final_report();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    initial begin
        void'($urandom(61609));
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            apb(1'h0, 12'h070 + 12'(4 * k), 32'h0);
            `CHK("reset", 32'h0, rd)
            apb(1'h1, 12'h070 + 12'(4 * k), 32'hFFFFFFFF);
            apb(1'h0, 12'h070 + 12'(4 * k), 32'h0);
            `CHK("width", k ? (k == 3 ? 32'h7 : 32'h3F) : 32'h3, rd)
        end
        apb(1'h0, 12'h200, 32'h0);
        `CHK("slverr", 1'h1, err)
        $display("registers done");
        w = $urandom;
        apb(1'h1, 12'h0C0, w);
        apb(1'h1, 12'h0D8, 32'h0);
        `CHK("ftw held", 32'h0, active_tuning_word)
        apb(1'h1, 12'h0D8, 32'h1);
        apb(1'h1, 12'h0C0, 32'h19999999);
        `CHK("ftw load", w, active_tuning_word)
        apb(1'h1, 12'h0D8, 32'h1);
        apb(1'h1, 12'h0D8, 32'h0);
        `CHK("ftw no edge", w, active_tuning_word)
        apb(1'h1, 12'h0D8, 32'h1);
        apb(1'h0, 12'h0C0, 32'h0);
        `CHK("ftw edge", 32'h19999999, active_tuning_word)
        $display("tuning done");
        for (int c = 0; c < 3; c++) begin
            apb(1'h1, 12'h070, m1s[c]);
            apb(1'h1, 12'h074, m2s[c]);
            apb(1'h1, 12'h078, m3s[c]);
            apb(1'h1, 12'h07C, ctl[c]);
            n_out = 2 << c;
            pm = ctl[c][0] & m1s[c][0];
            // 8x drains slowest, so it is the one that fills the buffer
            repeat (c == 2 ? 40 : 5)
                src_u.send(16'($urandom), 16'($urandom));
            for (int n = 0; eq.size() != 0; n++) begin
                if (n > 500) timeout();
                @(posedge pclk);
            end
            apb(1'h0, 12'h100, 32'h0);
            `CHK("status", 32'(2 * c + 3), rd)
            $display("mode set %0d done", c);
        end
        `CHK("refused", 1'h1, full)
        final_report();
    end
endmodule

// ### rtl/ifm_cfg.svh
`ifndef IFM_CFG_SVH
`define IFM_CFG_SVH
// register indices; the byte address is four times the index
`define IFM_IDX_MODE1 8'h1C
`define IFM_IDX_MODE2 8'h1D
`define IFM_IDX_MODE3 8'h1E
`define IFM_IDX_CTRL 8'h1F
`define IFM_IDX_FTW 8'h30
`define IFM_IDX_FTW_UPD 8'h36
`define IFM_IDX_STATUS 8'h40
`define IFM_MODE1_W 2
`define IFM_MODE23_W 6
`define IFM_CTRL_PREMOD 0
`define IFM_CTRL_EN2 1
`define IFM_CTRL_EN3 2
`define IFM_SAMPLE_W 16
`define IFM_FIFO_DEPTH 16
`define IFM_FIFO_AW 4
`endif

// ### rtl/ifm_fifo.sv
`timescale 1ns/1ps
module ifm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop;

    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// ### rtl/ifm_interp.sv
`timescale 1ns/1ps
`include "ifm_cfg.svh"
// What this block does
// - 2x interpolation passes 80% of input rate complex bandwidth.
// - 4x through first and second stages passes 50% to 80%.
// - second and third stages only run behind the always-on first stage, so enabling both gives 8x.
// - 4x mode outputs four samples per input sample.
// - 8x mode outputs eight samples per input sample.
// - mode fields at 0x1C..0x1E: 2-bit, 6-bit, 6-bit.
// - first stage mode 1 or 3 with premodulation shifts by half rate.
// - carrier frequency is tuning word over 2^32 times oscillator rate.
// - oscillator steps twice per input sample in 2x and 4x, four times in 8x.
// - new tuning word applies only on a 0 to 1 update bit edge.
module ifm_interp
    import ifm_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // input samples
    input wire logic in_valid,
    output logic in_ready,
    input wire ifm_pkg::ifm_sample_type in_i,
    input wire ifm_pkg::ifm_sample_type in_q,
    // output samples
    output logic out_valid,
    output ifm_pkg::ifm_sample_type out_i,
    output ifm_pkg::ifm_sample_type out_q,
    output logic [2:0] out_phase,
    output logic [31:0] carrier_phase,
    output logic [31:0] active_tuning_word
);
    import ifm_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] halfband_stage_one_mode;
    logic [5:0] halfband_stage_two_mode, halfband_stage_three_mode;
    logic [2:0] ctrl;
    logic [31:0] carrier_tuning_word;
    logic upd_bit;
    logic [1:0] next_m1;
    logic [5:0] next_m2, next_m3;
    logic [2:0] next_ctrl;
    logic [31:0] next_ftw, next_active;
    logic next_upd;
    logic wr, rd_hit;
    logic [7:0] idx;
    logic [31:0] prdata_c;
    logic fifo_level_bit, nco_double;
    logic [1:0] ratio_bits;

    // the index space is 8 bits, so the top two address bits stay zero
    function automatic logic [11:0] addr_of(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    assign idx = paddr[9:2];
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb begin
        next_m1 = halfband_stage_one_mode;
        next_m2 = halfband_stage_two_mode;
        next_m3 = halfband_stage_three_mode;
        next_ctrl = ctrl;
        next_ftw = carrier_tuning_word;
        next_upd = upd_bit;
        next_active = active_tuning_word;
        rd_hit = 1'b1;
        if (wr) begin
            if (paddr == addr_of(`IFM_IDX_MODE1))
                next_m1 = pwdata[1:0];
            else if (paddr == addr_of(`IFM_IDX_MODE2))
                next_m2 = pwdata[5:0];
            else if (paddr == addr_of(`IFM_IDX_MODE3))
                next_m3 = pwdata[5:0];
            else if (paddr == addr_of(`IFM_IDX_CTRL))
                next_ctrl = pwdata[2:0];
            else if (paddr == addr_of(`IFM_IDX_FTW))
                next_ftw = pwdata;
            else if (paddr == addr_of(`IFM_IDX_FTW_UPD)) begin
                next_upd = pwdata[0];
                if (!upd_bit && pwdata[0])
                    next_active = carrier_tuning_word;
            end
        end
        case (idx)
            `IFM_IDX_MODE1: prdata_c = {30'h0, halfband_stage_one_mode};
            `IFM_IDX_MODE2: prdata_c = {26'h0, halfband_stage_two_mode};
            `IFM_IDX_MODE3: prdata_c = {26'h0, halfband_stage_three_mode};
            `IFM_IDX_CTRL: prdata_c = {29'h0, ctrl};
            `IFM_IDX_FTW: prdata_c = carrier_tuning_word;
            `IFM_IDX_FTW_UPD: prdata_c = {31'h0, upd_bit};
            `IFM_IDX_STATUS: prdata_c = {28'h0, fifo_level_bit, ratio_bits,
                                         nco_double};
            default: begin
                prdata_c = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
        if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
            rd_hit = 1'b0;
    end
    assign pslverr = psel && penable && !rd_hit;
    assign prdata = (psel && !pwrite) ? prdata_c : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halfband_stage_one_mode <= 2'h0;
            halfband_stage_two_mode <= 6'h00;
            halfband_stage_three_mode <= 6'h00;
            ctrl <= 3'h0;
            carrier_tuning_word <= 32'h0;
            upd_bit <= 1'b0;
            active_tuning_word <= 32'h0;
        end else begin
            halfband_stage_one_mode <= next_m1;
            halfband_stage_two_mode <= next_m2;
            halfband_stage_three_mode <= next_m3;
            ctrl <= next_ctrl;
            carrier_tuning_word <= next_ftw;
            upd_bit <= next_upd;
            active_tuning_word <= next_active;
        end
    end

    // ------------------------------------------------------------
    // sample buffer
    // ------------------------------------------------------------
    logic f_valid, f_pop;
    logic [31:0] f_data;
    ifm_fifo #(.WIDTH(32), .DEPTH(`IFM_FIFO_DEPTH), .AW(`IFM_FIFO_AW)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data({in_i, in_q}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );
    assign fifo_level_bit = f_valid;

    // ------------------------------------------------------------
    // interpolation cascade (zero-order hold per stage; filter taps
    // are outside this block, only rate and coarse shift are kept)
    // ------------------------------------------------------------
    ifm_ratio_type ratio;
    logic st1_on, st2_on, st3_on;
    assign st1_on = 1'b1;
    assign st2_on = ctrl[`IFM_CTRL_EN2];
    assign st3_on = ctrl[`IFM_CTRL_EN3] && st2_on;
    always_comb begin
        // stage order fixed: a third stage alone is not a legal chain
        if (st3_on)
            ratio = IFM_X8;
        else if (st2_on)
            ratio = IFM_X4;
        else
            ratio = IFM_X2;
    end
    assign ratio_bits = ratio;
    assign nco_double = st1_on;

    function automatic logic [2:0] last_phase(input ifm_ratio_type r);
        case (r)
            IFM_X8: return 3'h7;
            IFM_X4: return 3'h3;
            IFM_X2: return 3'h1;
            default: return 3'h0;
        endcase
    endfunction

    logic [2:0] phase, next_phase;
    logic busy, next_busy;
    logic [31:0] held, next_held;
    logic premod_flip, next_flip;
    assign f_pop = f_valid && (!busy || phase == last_phase(ratio));

    always_comb begin
        next_phase = phase;
        next_busy = busy;
        next_held = held;
        next_flip = premod_flip;
        if (busy && phase != last_phase(ratio)) begin
            next_phase = phase + 3'h1;
        end else if (f_pop) begin
            next_phase = 3'h0;
            next_busy = 1'b1;
            next_held = f_data;
            next_flip = !premod_flip;
        end else begin
            next_busy = 1'b0;
        end
    end

    // premodulation by half input rate alternates sign per input sample
    logic premod_on;
    assign premod_on = ctrl[`IFM_CTRL_PREMOD] &&
                       halfband_stage_one_mode[0];

    function automatic ifm_sample_type neg(input ifm_sample_type v, input logic f);
        return f ? ifm_sample_type'(16'h0 - v) : v;
    endfunction

    // coarse shift of the second-stage modes 32..63: sign flip per output
    logic mod2;
    assign mod2 = halfband_stage_two_mode[5] && st2_on && phase[0];

    // ------------------------------------------------------------
    // fine modulator phase accumulator at oscillator rate
    // ------------------------------------------------------------
    logic [31:0] next_acc;
    always_comb begin
        next_acc = carrier_phase;
        if (busy && (phase[0] || ratio == IFM_X2))
            next_acc = carrier_phase + active_tuning_word;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 3'h0;
            busy <= 1'b0;
            held <= 32'h0;
            premod_flip <= 1'b0;
            carrier_phase <= 32'h0;
            out_valid <= 1'b0;
            out_i <= 16'h0;
            out_q <= 16'h0;
            out_phase <= 3'h0;
        end else begin
            phase <= next_phase;
            busy <= next_busy;
            held <= next_held;
            premod_flip <= next_flip;
            carrier_phase <= next_acc;
            out_valid <= busy;
            // flip toggles on each pop, so the first sample keeps its sign
            out_i <= neg(held[31:16], (premod_on && !premod_flip) ^ mod2);
            out_q <= neg(held[15:0], (premod_on && !premod_flip) ^ mod2);
            out_phase <= phase;
        end
    end
endmodule

// ### rtl/ifm_pkg.sv
package ifm_pkg;
    typedef enum logic [1:0] {
        IFM_X1,
        IFM_X2,
        IFM_X4,
        IFM_X8
    } ifm_ratio_type;
    typedef logic [15:0] ifm_sample_type;
endpackage
